// ==== hw/dtc_tmb.sv ====
// Timer B carrier / PWM engine: prescaler, down counter and output toggle flop.
// Assumes control fields from the register front end through dtc_tb_if.
`timescale 1ns/100ps
module dtc_tmb
  import dtc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  dtc_tb_if.eng tb
);
  logic [2:0] pre;
  logic tick;
  logic [7:0] count;
  logic udf;
  logic fire;
  logic tff;
  dtc_tb_state_e state;

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pre <= 3'h0;
    end else if (ce_in) begin
      pre <= pre + 3'h1;
    end
  end

  always_comb begin
    case (tb.clk_sel) // [R10]
      2'h0: tick = 1'b1;
      2'h1: tick = pre[0];
      2'h2: tick = &pre[1:0];
      default: tick = (pre == TB_PRE_MAX);
    endcase
  end

  assign udf = (state == DTC_TB_RUN) && tb.run && tick && (count == 8'h00);

  // Interval just ended is the one whose level the flop still shows
  always_comb begin
    case (tb.int_sel) // [R11]
      TB_IT_LOW: fire = udf && !tff;
      TB_IT_HIGH: fire = udf && tff;
      TB_IT_BOTH: fire = udf;
      default: fire = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state <= DTC_TB_IDLE;
      count <= 8'h00;
    end else if (ce_in) begin
      case (state)
        DTC_TB_IDLE: begin
          if (tb.run) begin // [R13]
            state <= DTC_TB_RUN;
            count <= tff ? tb.high_data : tb.low_data;
          end
        end
        DTC_TB_RUN: begin
          if (!tb.run) begin // [R13]
            state <= DTC_TB_IDLE;
          end else if (udf) begin
            if (tb.repeat_mode) begin // [R14]
              count <= tff ? tb.low_data : tb.high_data; // [R22]
            end else begin
              state <= DTC_TB_DONE;
            end
          end else if (tick) begin
            count <= count - 8'h01;
          end
        end
        default: begin
          // One shot ends here until software stops the timer
          if (!tb.run) begin
            state <= DTC_TB_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      tff <= 1'b0;
    end else if (ce_in) begin
      if (tb.level_wr) begin
        tff <= tb.level; // [R15]
      end else if (udf) begin
        tff <= !tff; // [R22]
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      tb.udf_evt <= 1'b0;
    end else if (ce_in) begin
      tb.udf_evt <= fire;
    end else begin
      tb.udf_evt <= 1'b0;
    end
  end

  assign tb.tff = tff;
endmodule // dtc_tmb

// ==== hw/dtc_top.sv ====
// Dual 8-bit timer block: AHB-Lite register slave, timer A and the shared pending flags.
// Assumes pins synchronous to mclk_in and one AHB-Lite master; timer B lives in dtc_tmb.
//
// Contract
// R1: Timer A clock field picks fxx/1024, fxx/256, fxx/64 or external clock pin.
// R2: Timer A mode 00 is interval mode driving the waveform pin.
// R3: Mode 01 captures count on capture rising edge; counter runs, overflow allowed.
// R4: Mode 10 captures count on capture falling edge; counter runs, overflow allowed.
// R5: Mode 11 is PWM; overflow interrupt still possible.
// R6: Writing one to timer A bit 3 clears the counter; zero does nothing.
// R7: Timer A bit 2 enables the overflow interrupt request.
// R8: Timer A bit 1 enables the match/capture interrupt request.
// R9: Timer A bit 0 starts or stops timer A.
// R10: Timer B clock field picks fxx divided by 1, 2, 4 or 8.
// R11: Timer B interrupt time: after low, high, or both intervals; 11 invalid.
// R12: Timer B bit 3 enables the underflow interrupt request.
// R13: Timer B bit 2 starts or stops timer B.
// R14: Timer B bit 1 selects one-shot or repeating operation.
// R15: Timer B bit 0 sets the output toggle flop level.
// R16: Pending bits: 2 timer B underflow, 1 timer A overflow, 0 match/capture.
// R17: Writing zero to a pending bit clears it.
// R18: Capture input comes from port 3 pin 6 when that pin is an input.
// R19: External clock comes from port 3 pin 5 when that pin is an input.
// R20: Interval mode flags match and restarts from zero when count equals data.
// R21: Writing one leaves a pending bit; flags set regardless of enables.
// R22: Repeating timer B reloads and toggles at each underflow, alternating intervals.
`timescale 1ns/100ps
module dtc_top
  import dtc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic timer_a_ext_clock_pin_in,
  input wire logic timer_a_capture_pin_in,
  input wire logic ext_clock_pin_is_input_in,
  input wire logic capture_pin_is_input_in,
  output logic timer_a_waveform_pin_out,
  output logic timer_a_pulse_output_out,
  output logic timer_b_toggle_flop_out,
  output logic timer_a_ovf_req_out,
  output logic timer_a_match_req_out,
  output logic timer_b_udf_req_out
);
  dtc_tb_if tb ();

  logic [7:0] ta_con;
  logic [7:0] tb_con;
  logic [7:0] ta_data;
  logic [7:0] ta_cap;
  logic [7:0] tb_low;
  logic [7:0] tb_high;
  logic [2:0] pend;
  logic [7:0] ta_count;
  logic [9:0] ta_pre;
  logic ext_prev;
  logic cap_prev;
  logic ta_tick;
  logic ext_rise;
  logic cap_edge;
  logic ta_ovf;
  logic ta_match;
  logic [1:0] ta_mode;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic addr_ok;
  logic [2:0] pend_set;
  logic [2:0] pend_clr;
  logic [7:0] rd_value;
  logic [7:0] wdata;
  logic level_wr;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] idx);
    reg_hit = (addr[9:2] == idx) && (addr[31:10] == 22'h0);
  endfunction

  function automatic logic wr_hit(input logic pend_wr, input logic [7:0] widx, input logic [7:0] idx);
    wr_hit = pend_wr && (widx == idx);
  endfunction

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  assign addr_ok = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);
  assign wdata = hwdata_in[7:0];

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else if (ce_in) begin
      wr_pend <= addr_ok && hwrite_in;
      wr_idx <= haddr_in[9:2];
    end
  end

  always_comb begin
    if (haddr_in[31:10] != 22'h0) begin
      rd_value = 8'h00;
    end else if (reg_hit(haddr_in, IDX_PEND)) begin
      rd_value = {5'h00, pend}; // [R16]
    end else if (reg_hit(haddr_in, IDX_TA_CON)) begin
      rd_value = ta_con;
    end else if (reg_hit(haddr_in, IDX_TA_DATA)) begin
      // Capture modes show the captured count through the data register
      rd_value = (ta_mode == TA_MODE_CAP_RISE || ta_mode == TA_MODE_CAP_FALL) ? ta_cap : ta_data;
    end else if (reg_hit(haddr_in, IDX_TA_COUNT)) begin
      rd_value = ta_count;
    end else if (reg_hit(haddr_in, IDX_TB_LOW)) begin
      rd_value = tb_low;
    end else if (reg_hit(haddr_in, IDX_TB_HIGH)) begin
      rd_value = tb_high;
    end else if (reg_hit(haddr_in, IDX_TB_CON)) begin
      rd_value = tb_con;
    end else begin
      rd_value = 8'h00;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      hrdata_out <= 32'h0;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else if (ce_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= HRESP_OKAY[0];
      if (addr_ok && !hwrite_in) begin
        hrdata_out <= {24'h0, rd_value};
      end
    end
  end

  // ---------------------------------------------------------------
  // Control and data registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ta_con <= CON_RESET;
    end else if (ce_in && wr_hit(wr_pend, wr_idx, IDX_TA_CON)) begin
      // Clear bit is a command and never stored
      ta_con <= wdata & ~(8'h01 << TA_CLEAR_BIT); // [R6]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      tb_con <= CON_RESET;
    end else if (ce_in && wr_hit(wr_pend, wr_idx, IDX_TB_CON)) begin
      tb_con <= wdata;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ta_data <= DATA_RESET;
      tb_low <= DATA_RESET;
      tb_high <= DATA_RESET;
    end else if (ce_in) begin
      if (wr_hit(wr_pend, wr_idx, IDX_TA_DATA)) begin
        ta_data <= wdata;
      end
      if (wr_hit(wr_pend, wr_idx, IDX_TB_LOW)) begin
        tb_low <= wdata;
      end
      if (wr_hit(wr_pend, wr_idx, IDX_TB_HIGH)) begin
        tb_high <= wdata;
      end
    end
  end

  assign level_wr = ce_in && wr_hit(wr_pend, wr_idx, IDX_TB_CON);

  // ---------------------------------------------------------------
  // Timer B link
  // ---------------------------------------------------------------
  assign tb.run = tb_con[TB_RUN_BIT]; // [R13]
  assign tb.repeat_mode = tb_con[TB_REPEAT_BIT]; // [R14]
  assign tb.clk_sel = tb_con[TB_CLK_LSB +: 2];
  assign tb.int_sel = tb_con[TB_ITIME_LSB +: 2];
  assign tb.low_data = tb_low;
  assign tb.high_data = tb_high;
  assign tb.level_wr = level_wr;
  assign tb.level = wdata[TB_LEVEL_BIT]; // [R15]

  dtc_tmb u_tmb (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .tb(tb.eng)
  );

  // ---------------------------------------------------------------
  // Timer A clocking and pin edges
  // ---------------------------------------------------------------
  assign ta_mode = ta_con[TA_MODE_LSB +: 2];

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ta_pre <= 10'h000;
      ext_prev <= 1'b0;
      cap_prev <= 1'b0;
    end else if (ce_in) begin
      ta_pre <= ta_pre + 10'h001;
      ext_prev <= timer_a_ext_clock_pin_in && ext_clock_pin_is_input_in; // [R19]
      cap_prev <= timer_a_capture_pin_in && capture_pin_is_input_in; // [R18]
    end
  end

  // A pin set as output is masked low, so no edge reaches the timer while it is an output; re-enabling it high gives one rising edge
  assign ext_rise = ext_clock_pin_is_input_in && timer_a_ext_clock_pin_in && !ext_prev; // [R19]

  always_comb begin
    cap_edge = 1'b0;
    if (capture_pin_is_input_in) begin // [R18]
      if (ta_mode == TA_MODE_CAP_RISE) begin
        cap_edge = timer_a_capture_pin_in && !cap_prev; // [R3]
      end else if (ta_mode == TA_MODE_CAP_FALL) begin
        cap_edge = !timer_a_capture_pin_in && cap_prev; // [R4]
      end
    end
  end

  always_comb begin
    case (ta_con[TA_CLK_LSB +: 2]) // [R1]
      TA_CLK_DIV1024: ta_tick = (ta_pre == TA_PRE_MAX);
      TA_CLK_DIV256: ta_tick = (ta_pre[7:0] == TA_PRE256_MAX);
      TA_CLK_DIV64: ta_tick = (ta_pre[5:0] == TA_PRE64_MAX);
      default: ta_tick = ext_rise;
    endcase
  end

  // ---------------------------------------------------------------
  // Timer A counter
  // ---------------------------------------------------------------
  // Interval mode wraps on match, and overflow is never flagged in interval mode
  assign ta_match = ta_con[TA_RUN_BIT] && ta_tick && (ta_mode == TA_MODE_INTERVAL) && (ta_count == ta_data);
  assign ta_ovf = ta_con[TA_RUN_BIT] && ta_tick && (ta_count == COUNT_MAX) && (ta_mode != TA_MODE_INTERVAL);

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ta_count <= 8'h00;
    end else if (ce_in) begin
      if (wr_hit(wr_pend, wr_idx, IDX_TA_CON) && wdata[TA_CLEAR_BIT]) begin
        ta_count <= 8'h00; // [R6]
      end else if (ta_match) begin
        ta_count <= 8'h00; // [R20]
      end else if (ta_con[TA_RUN_BIT] && ta_tick) begin
        ta_count <= ta_count + 8'h01; // [R9]
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ta_cap <= 8'h00;
    end else if (ce_in && cap_edge) begin
      ta_cap <= ta_count; // [R3] [R4]
    end
  end

  // ---------------------------------------------------------------
  // Timer A outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      timer_a_waveform_pin_out <= 1'b0;
      timer_a_pulse_output_out <= 1'b0;
    end else if (ce_in) begin
      if (ta_mode == TA_MODE_INTERVAL && ta_match) begin
        timer_a_waveform_pin_out <= !timer_a_waveform_pin_out; // [R2]
      end else if (ta_mode == TA_MODE_PWM) begin
        timer_a_waveform_pin_out <= (ta_count < ta_data); // [R5]
      end
      timer_a_pulse_output_out <= (ta_mode == TA_MODE_PWM) && ta_con[TA_RUN_BIT] && (ta_count < ta_data); // [R5]
    end
  end

  // ---------------------------------------------------------------
  // Pending flags
  // ---------------------------------------------------------------
  always_comb begin
    pend_set = 3'h0;
    pend_set[PEND_TB_UDF_BIT] = tb.udf_evt; // [R21]
    pend_set[PEND_TA_OVF_BIT] = ta_ovf; // [R3] [R4] [R5]
    pend_set[PEND_TA_MATCH_BIT] = ta_match || (ta_con[TA_RUN_BIT] && cap_edge); // [R20]
    pend_clr = 3'h0;
    if (wr_hit(wr_pend, wr_idx, IDX_PEND)) begin
      pend_clr = ~wdata[2:0]; // [R17]
    end
  end

  // Set beats a same-cycle clear so no event is lost
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pend <= PEND_RESET;
    end else if (ce_in) begin
      pend <= (pend & ~pend_clr) | pend_set; // [R16] [R17] [R21]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      timer_a_ovf_req_out <= 1'b0;
      timer_a_match_req_out <= 1'b0;
      timer_b_udf_req_out <= 1'b0;
      timer_b_toggle_flop_out <= 1'b0;
    end else if (ce_in) begin
      timer_a_ovf_req_out <= pend[PEND_TA_OVF_BIT] && ta_con[TA_OVF_IE_BIT]; // [R7]
      timer_a_match_req_out <= pend[PEND_TA_MATCH_BIT] && ta_con[TA_MATCH_IE_BIT]; // [R8]
      timer_b_udf_req_out <= pend[PEND_TB_UDF_BIT] && tb_con[TB_UDF_IE_BIT]; // [R12]
      timer_b_toggle_flop_out <= tb.tff;
    end
  end
endmodule // dtc_top

// ==== pkg/dtc_pkg.sv ====
// Constants, register indices and field positions of the dual 8-bit timer block.
// Assumes a single clock; every user imports the whole package.
package dtc_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_PEND = 8'hf2;
  localparam logic [7:0] IDX_TA_CON = 8'hf3;
  localparam logic [7:0] IDX_TA_DATA = 8'hf4;
  localparam logic [7:0] IDX_TA_COUNT = 8'hf5;
  localparam logic [7:0] IDX_TB_LOW = 8'hf6;
  localparam logic [7:0] IDX_TB_HIGH = 8'hf7;
  localparam logic [7:0] IDX_TB_CON = 8'hf8;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TA_CLK_LSB = 6;
  localparam int TA_MODE_LSB = 4;
  localparam int TA_CLEAR_BIT = 3;
  localparam int TA_OVF_IE_BIT = 2;
  localparam int TA_MATCH_IE_BIT = 1;
  localparam int TA_RUN_BIT = 0;
  localparam int TB_CLK_LSB = 6;
  localparam int TB_ITIME_LSB = 4;
  localparam int TB_UDF_IE_BIT = 3;
  localparam int TB_RUN_BIT = 2;
  localparam int TB_REPEAT_BIT = 1;
  localparam int TB_LEVEL_BIT = 0;
  localparam int PEND_TB_UDF_BIT = 2;
  localparam int PEND_TA_OVF_BIT = 1;
  localparam int PEND_TA_MATCH_BIT = 0;
  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] TA_CLK_DIV1024 = 2'h0;
  localparam logic [1:0] TA_CLK_DIV256 = 2'h1;
  localparam logic [1:0] TA_CLK_DIV64 = 2'h2;
  localparam logic [1:0] TA_CLK_EXT = 2'h3;
  localparam logic [1:0] TA_MODE_INTERVAL = 2'h0;
  localparam logic [1:0] TA_MODE_CAP_RISE = 2'h1;
  localparam logic [1:0] TA_MODE_CAP_FALL = 2'h2;
  localparam logic [1:0] TA_MODE_PWM = 2'h3;
  localparam logic [1:0] TB_IT_LOW = 2'h0;
  localparam logic [1:0] TB_IT_HIGH = 2'h1;
  localparam logic [1:0] TB_IT_BOTH = 2'h2;
  localparam logic [7:0] CON_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hff;
  localparam logic [2:0] PEND_RESET = 3'h0;
  localparam logic [9:0] TA_PRE_MAX = 10'h3ff;
  localparam logic [7:0] TA_PRE256_MAX = 8'hff;
  localparam logic [5:0] TA_PRE64_MAX = 6'h3f;
  localparam logic [2:0] TB_PRE_MAX = 3'h7;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic [1:0] {DTC_TB_IDLE, DTC_TB_RUN, DTC_TB_DONE} dtc_tb_state_e;
endpackage

// ==== pkg/dtc_tb_if.sv ====
// Carrier between the register front end and the timer B engine.
// Assumes both ends share mclk_in; the front end drives control, the engine drives status.
`timescale 1ns/100ps
interface dtc_tb_if;
  logic run;
  logic repeat_mode;
  logic [1:0] clk_sel;
  logic [1:0] int_sel;
  logic [7:0] low_data;
  logic [7:0] high_data;
  logic level_wr;
  logic level;
  logic udf_evt;
  logic tff;
  modport ctl (output run, repeat_mode, clk_sel, int_sel, low_data, high_data, level_wr, level,
               input udf_evt, tff);
  modport eng (input run, repeat_mode, clk_sel, int_sel, low_data, high_data, level_wr, level,
               output udf_evt, tff);
endinterface

// ==== testbench/dtc_pin_model.sv ====
// Pin model: drives the external clock and capture pins of timer A.
// Assumes push-pull drive, levels change right after a rising edge of mclk_in.
`timescale 1ns/100ps
module dtc_pin_model (
  input wire logic mclk_in,
  output logic ext_clock_out,
  output logic capture_out
);
  initial begin
    ext_clock_out = 1'b0;
    capture_out = 1'b0;
  end
  // Each level lasts at least one cycle so no edge is lost
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      ext_clock_out <= 1'b1;
      repeat (2) @(posedge mclk_in);
      ext_clock_out <= 1'b0;
    end
    @(posedge mclk_in);
  endtask
  // One capture edge, then settle
  task automatic cap(input logic lvl);
    @(posedge mclk_in);
    capture_out <= lvl;
    repeat (2) @(posedge mclk_in);
  endtask
endmodule // dtc_pin_model

// ==== testbench/dtc_top_props.sv ====
// Checker for the dual timer block, port level only.
// Assumes one clock and a synchronous active-high reset; bound to dtc_top.
`timescale 1ns/100ps
module dtc_top_props
  import dtc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic timer_a_waveform_pin_out,
  input wire logic timer_a_pulse_output_out,
  input wire logic timer_b_toggle_flop_out,
  input wire logic timer_a_ovf_req_out,
  input wire logic timer_a_match_req_out,
  input wire logic timer_b_udf_req_out
);
  // ----------------
  // Bus mirror
  // ----------------
  logic acc;
  logic wr_q;
  logic rd_pend;
  logic lvl_q;
  logic [7:0] wr_idx;
  logic [7:0] ta_m;
  logic [7:0] tb_m;
  logic [2:0] quiet;
  assign acc = hsel_in && hready_in && htrans_in == HTRANS_NONSEQ && ce_in;
  always_ff @(posedge mclk_in) begin
    wr_q <= !srst_in && acc && hwrite_in;
    rd_pend <= !srst_in && acc && !hwrite_in && haddr_in[9:2] == IDX_PEND;
    wr_idx <= haddr_in[9:2];
  end
  // Mirrors load at the data phase, as the real registers do
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ta_m <= 8'h00;
      tb_m <= 8'h00;
      lvl_q <= 1'b0;
    end else if (wr_q && wr_idx == IDX_TA_CON) begin
      ta_m <= hwdata_in[7:0];
    end else if (wr_q && wr_idx == IDX_TB_CON) begin
      tb_m <= hwdata_in[7:0];
      lvl_q <= hwdata_in[TB_LEVEL_BIT];
    end
  end
  // Cycles with timer B stopped and its control untouched
  always_ff @(posedge mclk_in) begin
    if (srst_in || tb_m[TB_RUN_BIT] || (wr_q && wr_idx == IDX_TB_CON)) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h4) begin
      quiet <= quiet + 3'h1;
    end
  end
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  sequence s_tb_stop_wr;
    wr_q && wr_idx == IDX_TB_CON && !hwdata_in[TB_RUN_BIT];
  endsequence
  sequence s_keep_wr;
    wr_q && wr_idx == IDX_PEND && hwdata_in[PEND_TA_MATCH_BIT];
  endsequence
  property p_wave;
    ($changed(timer_a_waveform_pin_out) && ta_m[5:4] == TA_MODE_INTERVAL && $past(ta_m[5:4]) == TA_MODE_INTERVAL
      && ta_m[TA_MATCH_IE_BIT] && $past(ta_m[TA_MATCH_IE_BIT])) |-> ##[0:2] timer_a_match_req_out;
  endproperty
  property p_pwm_off;
    ((ta_m[5:4] != TA_MODE_PWM || !ta_m[TA_RUN_BIT]) && ($past(ta_m[5:4]) != TA_MODE_PWM || !$past(ta_m[0])))
      |-> !timer_a_pulse_output_out;
  endproperty
  a_level_follow: assert property (s_tb_stop_wr |=> ##[1:2] timer_b_toggle_flop_out == lvl_q)
    else $error("toggle flop misses written level");
  a_pend_unused: assert property (rd_pend |-> hrdata_out[31:3] == 29'h0)
    else $error("unused pending bits nonzero");
  a_ovf_gate: assert property ((!ta_m[2] && !$past(ta_m[2])) |-> !timer_a_ovf_req_out)
    else $error("overflow request while disabled");
  a_match_gate: assert property ((!ta_m[1] && !$past(ta_m[1])) |-> !timer_a_match_req_out)
    else $error("match request while disabled");
  a_udf_gate: assert property ((!tb_m[3] && !$past(tb_m[3])) |-> !timer_b_udf_req_out)
    else $error("underflow request while disabled");
  a_keep_one: assert property ((s_keep_wr ##0 (timer_a_match_req_out && ta_m[1])) |=> timer_a_match_req_out [*2])
    else $error("pending bit lost on write of one");
  a_wave_match: assert property (p_wave)
    else $error("waveform toggled without match");
  a_pwm_idle: assert property (p_pwm_off)
    else $error("pulse output high outside running pwm");
  a_tb_stopped: assert property (quiet == 3'h4 |-> $stable(timer_b_toggle_flop_out))
    else $error("stopped timer b toggled");
endmodule // dtc_top_props

bind dtc_top dtc_top_props dtc_top_props_inst (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .timer_a_waveform_pin_out(timer_a_waveform_pin_out),
  .timer_a_pulse_output_out(timer_a_pulse_output_out), .timer_b_toggle_flop_out(timer_b_toggle_flop_out),
  .timer_a_ovf_req_out(timer_a_ovf_req_out), .timer_a_match_req_out(timer_a_match_req_out),
  .timer_b_udf_req_out(timer_b_udf_req_out));

// ==== testbench/tb_top.sv ====
// Testbench for the dual timer block: bus master, pin model, queued read checks.
// Assumes a zero-wait AHB-Lite slave and a 50 MHz clock.
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import dtc_pkg::*;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic hwrite_in = 1'b0;
  logic rd_vld = 1'b0;
  logic ext_cfg = 1'b1;
  logic cap_cfg = 1'b1;
  logic [1:0] htrans_in = 2'h0;
  logic [31:0] haddr_in = 32'h0;
  logic [31:0] hwdata_in = 32'h0;
  logic [31:0] hrdata_out, head;
  logic hreadyout_out, hresp_out, ext_pin, cap_pin, wave, pwm, tff, ovf_req, match_req, udf_req;
  logic [31:0] expq[$];
  int errors = 0;
  int checks = 0;
  int seed = 32'h701c;
  dtc_top dtc_top_inst (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce_in), .hsel_in(1'b1), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .timer_a_ext_clock_pin_in(ext_pin),
    .timer_a_capture_pin_in(cap_pin), .ext_clock_pin_is_input_in(ext_cfg), .capture_pin_is_input_in(cap_cfg),
    .timer_a_waveform_pin_out(wave), .timer_a_pulse_output_out(pwm), .timer_b_toggle_flop_out(tff),
    .timer_a_ovf_req_out(ovf_req), .timer_a_match_req_out(match_req), .timer_b_udf_req_out(udf_req));
  dtc_pin_model dtc_pin_model_inst (.mclk_in(mclk_in), .ext_clock_out(ext_pin), .capture_out(cap_pin));
  initial begin
    forever #10 mclk_in = ~mclk_in;
  end
  // Read data is judged at the data-phase edge against the oldest note
  always @(posedge mclk_in) begin
    if (rd_vld === 1'b1) begin
      head = expq.pop_front();
      `CHK(hrdata_out, head)
      `CHK(hresp_out, 1'b0)
    end
  end
  // One single transfer; the trailing idle keeps a read off a fresh write
  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
    haddr_in <= {22'h0, idx, 2'h0};
    hwrite_in <= w;
    htrans_in <= HTRANS_NONSEQ;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= {24'h0, d};
    rd_vld <= !w;
    if (!w) expq.push_back({24'h0, d});
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    rd_vld <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic wait_tff(input logic v, output int k);
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (tff !== v);
  endtask
  task automatic summarize();
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    int d, lo, k1, k2;
    logic [1:0] m;
    repeat (16) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(posedge mclk_in);
    bus(IDX_PEND, 0, 8'h00);
    bus(IDX_TA_CON, 0, CON_RESET);
    bus(IDX_TB_CON, 0, CON_RESET);
    bus(8'h10, 0, 8'h00);
    d = 2 + ($random(seed) & 7);
    lo = 4 + ($random(seed) & 7);
    bus(IDX_TA_DATA, 1, d[7:0]);
    bus(IDX_TA_CON, 1, 8'hc3);
    dtc_pin_model_inst.pulse(d);
    bus(IDX_TA_COUNT, 0, d[7:0]);
    ce_in <= 1'b0;
    dtc_pin_model_inst.pulse(1);
    ce_in <= 1'b1;
    dtc_pin_model_inst.pulse(1);
    bus(IDX_TA_COUNT, 0, 8'h00);
    `CHK(match_req, 1'b1)
    `CHK(wave, 1'b1)
    bus(IDX_PEND, 1, 8'h07);
    bus(IDX_PEND, 0, 8'h01);
    bus(IDX_PEND, 1, 8'h00);
    bus(IDX_PEND, 0, 8'h00);
    ext_cfg <= 1'b0;
    dtc_pin_model_inst.pulse(2);
    bus(IDX_TA_COUNT, 0, 8'h00);
    ext_cfg <= 1'b1;
    bus(IDX_TA_CON, 1, 8'hc2);
    dtc_pin_model_inst.pulse(2);
    bus(IDX_TA_COUNT, 0, 8'h00);
    // Capture with match interrupt masked: flag must still rise
    for (m = 2'h1; m <= 2'h2; m++) begin
      bus(IDX_TA_CON, 1, {TA_CLK_EXT, m, 4'h9});
      dtc_pin_model_inst.pulse(2 * m + 1);
      dtc_pin_model_inst.cap(m == 2'h1);
      bus(IDX_TA_DATA, 0, 8'(2 * m + 1));
      bus(IDX_PEND, 0, 8'h01);
      `CHK(match_req, 1'b0)
      bus(IDX_PEND, 1, 8'h00);
    end
    cap_cfg <= 1'b0;
    dtc_pin_model_inst.cap(1'b1);
    dtc_pin_model_inst.cap(1'b0);
    bus(IDX_PEND, 0, 8'h00);
    bus(IDX_TA_DATA, 1, 8'h80);
    bus(IDX_TA_CON, 1, 8'hfd);
    dtc_pin_model_inst.pulse(256);
    bus(IDX_PEND, 0, 8'h02);
    `CHK(ovf_req, 1'b1)
    `CHK(pwm, 1'b1)
    bus(IDX_TA_CON, 1, 8'h00);
    bus(IDX_PEND, 1, 8'h00);
    bus(IDX_TB_CON, 1, 8'h01);
    repeat (2) @(posedge mclk_in);
    `CHK(tff, 1'b1)
    bus(IDX_TB_CON, 1, 8'h00);
    repeat (2) @(posedge mclk_in);
    `CHK(tff, 1'b0)
    bus(IDX_TB_LOW, 1, lo[7:0]);
    bus(IDX_TB_HIGH, 1, 8'h09);
    for (int c = 0; c < 4; c++) begin
      bus(IDX_TB_CON, 1, {c[1:0], 2'(c % 3), 4'he});
      wait_tff(1'b1, k1);
      repeat (3) @(posedge mclk_in);
      `CHK(udf_req, 1'(c != 1))
      wait_tff(1'b0, k1);
      wait_tff(1'b1, k2);
      `CHK(k1 + k2 + 3, (lo + 11) << c)
      bus(IDX_TB_CON, 1, 8'h00);
      bus(IDX_PEND, 1, 8'h00);
    end
    bus(IDX_TB_CON, 1, 8'h0c);
    repeat (lo + 15) @(posedge mclk_in);
    `CHK(tff, 1'b1)
    bus(IDX_TB_CON, 1, 8'h00);
    summarize();
  end
  initial begin
    repeat (60000) @(posedge mclk_in);
    errors++;
    summarize();
  end
endmodule // tb_top
